// >>> hdl/compare_skip_less_exec.sv
/*
 * Execute stage for compare_skip_less: compares a data byte with the accumulator
 * and, when the byte is lower, squashes the prefetched instruction for one cycle.
 * Assumes the core presents one instruction per clock with a start pulse and
 * supplies the data byte read from the target address in the same cycle.
 * Every output leaves a flop; the write strobes only show that a compare writes nothing.
 */
`timescale 1ns/1ps
`include "cmp_skip_params.svh"

module compare_skip_less_exec
    import cmp_skip_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  reset,
    input  wire logic  execStart,
    input  wire addr_t targetAddr,
    input  wire byte_t targetByte,
    input  wire byte_t accValue,
    output logic       memReadEn,
    output addr_t      memReadAddr,
    output logic       prefetchFlush,
    output logic       nopActive,
    output logic       skipTaken,
    output logic       execBusy,
    output logic       execDone,
    output logic       flagWriteEn,
    output logic       accWriteEn,
    output logic       memWriteEn,
    output logic [1:0] cycleCount
);
    exec_state_t state_r;
    logic        isLess;
    logic [1:0]  cycCnt_r;
    logic        skipTaken_r;
    logic        flush_r;
    logic        done_r;
    logic        rdEn_r;
    addr_t       rdAddr_r;
    logic        flagWe_r;
    logic        accWe_r;
    logic        memWe_r;
    logic        startIdle;

    less_compare #(.WIDTH(`CSL_DATA_W)) u_cmp (
        .memByte   (targetByte),
        .accValue  (accValue),
        .isLess    (isLess),
        .diffValue ()
    );

    // A start counts only outside the squash slot
    assign startIdle = execStart && (state_r == ST_IDLE);

    // Address is registered so the memory read port sees it from a flop
    always_ff @(posedge clk) begin
        if (reset) begin
            rdEn_r   <= 1'b0;
            rdAddr_r <= '0;
        end else begin
            rdEn_r   <= startIdle;
            rdAddr_r <= startIdle ? targetAddr : rdAddr_r;
        end
    end

    // A start arriving during the squash cycle is ignored: the fetched word is a NOP slot
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (execStart && isLess) state_r <= ST_NOP;
                end
                ST_NOP: begin
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Skip marker and flush pulse both cover exactly the squashed slot
    always_ff @(posedge clk) begin
        if (reset) begin
            skipTaken_r <= 1'b0;
            flush_r     <= 1'b0;
        end else begin
            skipTaken_r <= startIdle && isLess;
            flush_r     <= startIdle && isLess;
        end
    end

    // Count outlives the strobe so the core may read it after completion
    always_ff @(posedge clk) begin
        if (reset) begin
            done_r      <= 1'b0;
            cycCnt_r    <= 2'h0;
        end else begin
            if (startIdle && !isLess) begin
                done_r   <= 1'b1;
                cycCnt_r <= `CSL_CYC_NOSKIP;
            end else if (state_r == ST_NOP) begin
                done_r   <= 1'b1;
                cycCnt_r <= `CSL_CYC_SKIP;
            end else begin
                done_r   <= 1'b0;
                cycCnt_r <= cycCnt_r;
            end
        end
    end

    assign memReadEn     = rdEn_r;
    assign memReadAddr   = rdAddr_r;
    assign prefetchFlush = flush_r;
    assign nopActive     = flush_r;
    assign skipTaken     = skipTaken_r;
    assign execBusy      = flush_r;
    assign execDone      = done_r;
    assign cycleCount    = cycCnt_r;
    assign flagWriteEn   = flagWe_r;
    assign accWriteEn    = accWe_r;
    assign memWriteEn    = memWe_r;

    // Compare only: the write strobes sit in flops like every other output and never rise
    always_ff @(posedge clk) begin
        if (reset) begin
            flagWe_r <= 1'b0;
            accWe_r  <= 1'b0;
            memWe_r  <= 1'b0;
        end else begin
            flagWe_r <= 1'b0;
            accWe_r  <= 1'b0;
            memWe_r  <= 1'b0;
        end
    end

    // Compare expectations below are worked from the operands, not from the comparator's isLess result
    skip_when_less_a: assert property (@(posedge clk) disable iff (reset)
        startIdle && (targetByte < accValue) |=> skipTaken && prefetchFlush)
        else $error("skip missing for byte below accumulator");

    no_skip_ge_a: assert property (@(posedge clk) disable iff (reset)
        startIdle && (targetByte >= accValue) |=> !skipTaken && execDone)
        else $error("skip taken for byte not below accumulator");

    flush_one_cycle_a: assert property (@(posedge clk) disable iff (reset)
        prefetchFlush |=> !prefetchFlush)
        else $error("flush held longer than one cycle");

    nop_replaces_a: assert property (@(posedge clk) disable iff (reset)
        prefetchFlush |-> nopActive)
        else $error("flush without nop");

    skip_two_cycles_a: assert property (@(posedge clk) disable iff (reset)
        startIdle && (targetByte < accValue) |=> !execDone ##1 execDone && cycleCount == 2'h2)
        else $error("skip not completed in two cycles");

    noskip_one_cycle_a: assert property (@(posedge clk) disable iff (reset)
        startIdle && (targetByte >= accValue) |=> cycleCount == 2'h1)
        else $error("no-skip not one cycle");

    flags_kept_a: assert property (@(posedge clk) disable iff (reset)
        !flagWriteEn)
        else $error("status flags written");

    operands_kept_a: assert property (@(posedge clk) disable iff (reset)
        $rose(memReadEn) |-> !accWriteEn && !memWriteEn)
        else $error("operand written by compare");

    refused_start_a: assert property (@(posedge clk) disable iff (reset)
        execStart && (state_r == ST_NOP) |=> !skipTaken && !memReadEn && execDone)
        else $error("start in no-operation slot was acted on");

    read_issue_a: assert property (@(posedge clk) disable iff (reset)
        startIdle |=> memReadEn && (memReadAddr == $past(targetAddr)))
        else $error("operand read not issued at the target address");

    read_quiet_a: assert property (@(posedge clk) disable iff (reset)
        !startIdle |=> !memReadEn)
        else $error("operand read without an accepted start");

    busy_in_nop_a: assert property (@(posedge clk) disable iff (reset)
        execBusy |-> (state_r == ST_NOP))
        else $error("busy outside the no-operation slot");

    skip_cause_a: assert property (@(posedge clk) disable iff (reset)
        skipTaken |-> $past(startIdle) && ($past(targetByte) < $past(accValue)))
        else $error("skip without a lower byte");

    done_count_a: assert property (@(posedge clk) disable iff (reset)
        execDone |-> (cycleCount == `CSL_CYC_NOSKIP) || (cycleCount == `CSL_CYC_SKIP))
        else $error("completion with an illegal cycle count");

    state_legal_a: assert property (@(posedge clk) disable iff (reset)
        (state_r == ST_IDLE) || (state_r == ST_NOP))
        else $error("sequencer in an unused code");

    writes_kept_a: assert property (@(posedge clk) disable iff (reset)
        !accWriteEn && !memWriteEn)
        else $error("operand write strobe raised");

    equal_no_skip_a: assert property (@(posedge clk) disable iff (reset)
        startIdle && (targetByte == accValue) |=> !skipTaken && execDone)
        else $error("equal operands caused a skip");

    count_held_a: assert property (@(posedge clk) disable iff (reset)
        !execDone && !$past(reset) |-> $stable(cycleCount))
        else $error("cycle count changed without completion");

    nop_done_a: assert property (@(posedge clk) disable iff (reset)
        (state_r == ST_NOP) |=> execDone && !prefetchFlush)
        else $error("no-operation slot did not complete");

    // Main scenarios, including the refused start and back-to-back issue
    skip_path_c: cover property (@(posedge clk) disable iff (reset) startIdle && targetByte < accValue);
    noskip_path_c: cover property (@(posedge clk) disable iff (reset) startIdle && targetByte >= accValue);
    equal_path_c: cover property (@(posedge clk) disable iff (reset) startIdle && targetByte == accValue);
    nop_refused_c: cover property (@(posedge clk) disable iff (reset) execStart && (state_r == ST_NOP));
    back_to_back_c: cover property (@(posedge clk) disable iff (reset) startIdle ##1 startIdle);
endmodule // compare_skip_less_exec

// >>> include/cmp_skip_params.svh
/*
 * Timing and width constants for the compare-and-skip-if-less execution block.
 * Assumes inclusion by bare name from the package and from design files.
 */
`ifndef CMP_SKIP_PARAMS_SVH
`define CMP_SKIP_PARAMS_SVH

`define CSL_DATA_W        8
`define CSL_ADDR_W        8
`define CSL_ADDR_MAX      8'hFF
`define CSL_CYC_NOSKIP    2'h1
`define CSL_CYC_SKIP      2'h2
`define CSL_TCY_NS        50
`define CSL_CLK_NS        50
`define CSL_TCY_CLKS      ((`CSL_TCY_NS + `CSL_CLK_NS - 1) / `CSL_CLK_NS)

`endif

// >>> include/cmp_skip_pkg.sv
/*
 * Types shared by the compare-and-skip-if-less execution block.
 * Assumes cmp_skip_params.svh is on the include path.
 */
`include "cmp_skip_params.svh"

package cmp_skip_pkg;
    typedef logic [`CSL_DATA_W-1:0] byte_t;
    typedef logic [`CSL_ADDR_W-1:0] addr_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_NOP  = 2'h1
    } exec_state_t;
endpackage

// >>> hdl/less_compare.sv
/*
 * Unsigned magnitude compare of a memory byte against the accumulator.
 * Assumes both operands are stable in the cycle that samples the result.
 */
`timescale 1ns/1ps
`include "cmp_skip_params.svh"

module less_compare
    import cmp_skip_pkg::*;
#(
    parameter int WIDTH = `CSL_DATA_W
) (
    input  wire logic [WIDTH-1:0] memByte,
    input  wire logic [WIDTH-1:0] accValue,
    output logic                  isLess,
    output logic [WIDTH-1:0]      diffValue
);
    logic [WIDTH:0] diffWide;

    // Borrow out of the subtraction is the unsigned less-than result
    assign diffWide  = {1'b0, memByte} - {1'b0, accValue};
    assign isLess    = diffWide[WIDTH];
    assign diffValue = diffWide[WIDTH-1:0];
endmodule // less_compare

// >>> testbench/data_mem_model.sv
/* Data memory model that answers the block's byte fetch.
   Assumes the address is held for the whole start cycle; read is combinational. */
`timescale 1ns/1ps

module data_mem_model (
    input  wire logic [7:0] addr,
    output logic [7:0]      rdData
);
    // Fixed pattern so the bench can predict every byte without a store
    assign rdData = addr ^ 8'h5A;
endmodule // data_mem_model

// >>> testbench/compare_skip_less_exec_test.sv
/* Self-checking bench for the compare-and-skip-if-less execute block.
   Assumes data_mem_model and the design package are compiled first. */
`timescale 1ns/1ps

module compare_skip_less_exec_test;
    import cmp_skip_pkg::*;
    typedef struct {addr_t a; byte_t w; logic s;} row_t;
    logic clk = 0, reset = 1, execStart = 0;
    addr_t targetAddr = 8'h00;
    byte_t targetByte, accValue = 8'h00, memReadAddr;
    logic memReadEn, prefetchFlush, nopActive, skipTaken, execBusy, execDone;
    logic flagWriteEn, accWriteEn, memWriteEn;
    logic [1:0] cycleCount;
    int bad_count = 0, samples_checked = 0, cycles = 0;
    // Memory byte is a ^ 5A: boundaries 00, 01, FF, and 7F/80 where a signed compare would differ
    row_t rows[8] = '{'{8'h5A, 8'h00, 0}, '{8'h5A, 8'h01, 1}, '{8'hA5, 8'hFF, 0},
                      '{8'h5B, 8'h02, 1}, '{8'h5B, 8'h01, 0}, '{8'hA5, 8'h00, 0},
                      '{8'hDA, 8'h7F, 0}, '{8'h25, 8'h80, 1}};

    data_mem_model data_mem_model_i (.addr(targetAddr), .rdData(targetByte));
    compare_skip_less_exec compare_skip_less_exec_i (.clk(clk), .reset(reset), .execStart(execStart),
        .targetAddr(targetAddr), .targetByte(targetByte), .accValue(accValue), .memReadEn(memReadEn),
        .memReadAddr(memReadAddr), .prefetchFlush(prefetchFlush), .nopActive(nopActive),
        .skipTaken(skipTaken), .execBusy(execBusy), .execDone(execDone), .flagWriteEn(flagWriteEn),
        .accWriteEn(accWriteEn), .memWriteEn(memWriteEn), .cycleCount(cycleCount));

    always #25 clk = ~clk;

    task results;
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 200) begin
            bad_count++;
            results();
        end
    end

    task chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task issue(input addr_t a, input byte_t w);
        @(posedge clk);
        #1 execStart = 1;
        targetAddr = a;
        accValue = w;
    endtask

    task idle;
        @(posedge clk);
        #1 execStart = 0;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        #1 reset = 0;
        chk(cycleCount, 0);
        chk({execDone, skipTaken, execBusy, memReadEn}, 0);
        foreach (rows[i]) begin
            issue(rows[i].a, rows[i].w);
            idle;
            chk({skipTaken, prefetchFlush, nopActive, execBusy}, {4{rows[i].s}});
            chk(execDone, !rows[i].s);
            chk(memReadEn, 1);
            chk(memReadAddr, rows[i].a);
            chk({flagWriteEn, accWriteEn, memWriteEn}, 0);
            idle;
            chk(execDone, rows[i].s);
            chk(skipTaken, 0);
            chk(cycleCount, rows[i].s ? 2 : 1);
        end
        // A start landing in the no-operation slot must be ignored
        issue(8'h5B, 8'h02);
        issue(8'h5A, 8'hFF);
        chk(skipTaken, 1);
        idle;
        chk({execDone, skipTaken, cycleCount}, 8'h0A);
        chk(memReadEn, 0);
        chk(memReadAddr, 8'h5B);
        idle;
        chk({execDone, skipTaken, memReadEn}, 0);
        // Back-to-back starts that do not skip
        issue(8'hA5, 8'h10);
        issue(8'h5A, 8'h00);
        chk({execDone, cycleCount}, 5);
        chk(memReadAddr, 8'hA5);
        idle;
        chk(execDone, 1);
        chk(memReadAddr, 8'h5A);
        idle;
        chk({execDone, flagWriteEn, accWriteEn, memWriteEn}, 0);
        // Reset inside the no-operation slot clears everything; restart right after release
        issue(8'h5B, 8'h02);
        idle;
        chk(skipTaken, 1);
        reset = 1;
        @(posedge clk);
        #1 reset = 0;
        chk({execDone, skipTaken, prefetchFlush, memReadEn, cycleCount}, 0);
        chk(memReadAddr, 0);
        issue(8'hA5, 8'h10);
        idle;
        chk({execDone, skipTaken, cycleCount}, 8'h09);
        idle;
        results();
    end
endmodule // compare_skip_less_exec_test
